// >>> pif_pkg.sv
/*
  Package for the peripheral interrupt flag block: register offsets,
  bit positions, reset values and the event carrier struct.
  Assumes a plain register port with byte-wide data in the low bits.
*/
package pif_pkg;

   localparam int PIF_ADDR_W = 4;
   localparam int PIF_DATA_W = 8;

   // register offsets, chosen for this block
   localparam logic [3:0] PIF_OFS_ENABLE = 4'h0;
   localparam logic [3:0] PIF_OFS_FLAGS = 4'h1;
   localparam logic [3:0] PIF_OFS_CTRL = 4'h2;
   localparam logic [3:0] PIF_OFS_STATUS = 4'h3;

   // field positions shared by the enable and flag registers
   localparam int PIF_BIT_EEPROM = 7;
   localparam int PIF_BIT_ADC = 6;
   localparam int PIF_BIT_CAPCOMP = 5;
   localparam int PIF_BIT_CMP_TWO = 4;
   localparam int PIF_BIT_CMP_ONE = 3;
   localparam int PIF_BIT_OSC_FAIL = 2;
   localparam int PIF_BIT_TMR_TWO = 1;
   localparam int PIF_BIT_TMR_ONE = 0;

   // control register field positions
   localparam int PIF_BIT_GLOBAL_EN = 7;
   localparam int PIF_BIT_PERIPH_EN = 6;

   // capture/compare unit modes
   localparam logic [1:0] PIF_CCP_OFF = 2'h0;
   localparam logic [1:0] PIF_CCP_CAPTURE = 2'h1;
   localparam logic [1:0] PIF_CCP_COMPARE = 2'h2;
   localparam logic [1:0] PIF_CCP_PWM = 2'h3;

   // reset values
   localparam logic [7:0] PIF_RST_ENABLE = 8'h00;
   localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
   localparam logic [7:0] PIF_RST_CTRL = 8'h00;
   localparam logic [7:0] PIF_RST_READ = 8'h00;

   // raw event inputs from the peripherals, one cycle pulses or levels
   typedef struct packed {
      logic eeprom_write_done;
      logic adc_conv_done;
      logic capture_event;
      logic compare_match;
      logic [1:0] ccp_mode;
      logic comparator_two_out;
      logic comparator_one_out;
      logic osc_failed;
      logic timer_two_match;
      logic timer_one_overflow;
   } pif_events_s;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pif_req_s;

endpackage

// >>> pif_edge.sv
/*
  Change detector for the comparator outputs: one pulse per change.
  Assumes the comparator outputs are already synchronous to mclk.
*/
module pif_edge
   import pif_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] changed
);

   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] primed;

   // one stage per comparator; no pulse until a first level is held
   for (genvar i = 0; i < WIDTH; i++) begin : g_chan
      always_ff @(posedge mclk) begin
         if (!reset_n) begin
            level_q[i] <= 1'b0;
            primed[i] <= 1'b0;
         end else begin
            level_q[i] <= level[i];
            primed[i] <= 1'b1;
         end
      end
      // the reset value is not a real output, so skip the first compare
      assign changed[i] = primed[i] & (level_q[i] ^ level[i]);
   end

endmodule

// >>> pif_flags.sv
/*
  Peripheral interrupt enable and flag registers with the request output.
  Assumes peripheral events synchronous to mclk and a simple register port
  with read data one cycle after the read strobe.
*/
// What this block does
// - eight-bit enable register, fixed source order
// - enable one passes, zero blocks; resets zero
// - flags set regardless of any enable
// - bit 7 sets on eeprom write done
// - bit 6 sets on conversion complete
// - bit 5 capture or compare; PWM unused
// - bits 4,3 set on comparator change
// - bit 2 sets on oscillator failure
// - bit 1 sets on timer two match
// - bit 0 sets on timer one overflow
// - flags readable, writable, reset to zero
module pif_flags
   import pif_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [PIF_ADDR_W-1:0] reg_addr,
   input wire logic [PIF_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [PIF_DATA_W-1:0] reg_rdata,
   input wire pif_events_s events,
   output logic periph_irq,
   output logic periph_pending
);

   logic [7:0] peripheral_irq_enable;
   logic [7:0] peripheral_irq_flags;
   logic [7:0] core_ctrl;
   logic [7:0] hw_set;
   logic [7:0] next_flags;
   logic [1:0] cmp_changed;
   logic wr_enable;
   logic wr_flags;
   logic wr_ctrl;
   logic [7:0] pending;

   pif_req_s req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // address decode for writes
   assign wr_enable = req.wr && (req.addr == PIF_OFS_ENABLE);
   assign wr_flags = req.wr && (req.addr == PIF_OFS_FLAGS);
   assign wr_ctrl = req.wr && (req.addr == PIF_OFS_CTRL);

   // comparator outputs only count when they toggle
   pif_edge #(
      .WIDTH(2)
   ) u_cmp_edge (
      .mclk(mclk),
      .reset_n(reset_n),
      .level({events.comparator_two_out, events.comparator_one_out}),
      .changed(cmp_changed)
   );

   // hardware set terms; none looks at any enable bit
   always_comb begin
      hw_set = 8'h00;
      hw_set[PIF_BIT_EEPROM] = events.eeprom_write_done;
      hw_set[PIF_BIT_ADC] = events.adc_conv_done;
      // capture and compare share the bit; PWM leaves it alone
      case (events.ccp_mode)
         PIF_CCP_CAPTURE: hw_set[PIF_BIT_CAPCOMP] = events.capture_event;
         PIF_CCP_COMPARE: hw_set[PIF_BIT_CAPCOMP] = events.compare_match;
         default: hw_set[PIF_BIT_CAPCOMP] = 1'b0;
      endcase
      hw_set[PIF_BIT_CMP_TWO] = cmp_changed[1];
      hw_set[PIF_BIT_CMP_ONE] = cmp_changed[0];
      hw_set[PIF_BIT_OSC_FAIL] = events.osc_failed;
      hw_set[PIF_BIT_TMR_TWO] = events.timer_two_match;
      hw_set[PIF_BIT_TMR_ONE] = events.timer_one_overflow;
   end

   // software write first, hardware set ORed on top so it always wins
   always_comb begin
      next_flags = peripheral_irq_flags;
      if (wr_flags) begin
         next_flags = req.wdata;
      end
      next_flags = next_flags | hw_set;
   end

   // flag register: sticky until software writes a zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         peripheral_irq_flags <= PIF_RST_FLAGS;
      end else begin
         peripheral_irq_flags <= next_flags;
      end
   end

   // enable register, one bit per source in flag order
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         peripheral_irq_enable <= PIF_RST_ENABLE;
      end else if (wr_enable) begin
         peripheral_irq_enable <= req.wdata;
      end
   end

   // global and peripheral master enables stand in for the core control bits
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         core_ctrl <= PIF_RST_CTRL;
      end else if (wr_ctrl) begin
         core_ctrl <= req.wdata & 8'hc0;
      end
   end

   assign pending = peripheral_irq_flags & peripheral_irq_enable;

   // request output registered; a stale flag fires at once if enabled, so
   // software clears it before setting the enable
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         periph_irq <= 1'b0;
         periph_pending <= 1'b0;
      end else begin
         periph_pending <= |pending;
         periph_irq <= (|pending) && core_ctrl[PIF_BIT_PERIPH_EN]
                       && core_ctrl[PIF_BIT_GLOBAL_EN];
      end
   end

   // read data valid only in the cycle after the strobe; zero otherwise
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         reg_rdata <= PIF_RST_READ;
      end else if (req.rd) begin
         case (req.addr)
            PIF_OFS_ENABLE: reg_rdata <= peripheral_irq_enable;
            PIF_OFS_FLAGS: reg_rdata <= peripheral_irq_flags;
            PIF_OFS_CTRL: reg_rdata <= core_ctrl;
            PIF_OFS_STATUS: reg_rdata <= pending;
            default: reg_rdata <= PIF_RST_READ;
         endcase
      end else begin
         reg_rdata <= PIF_RST_READ;
      end
   end

endmodule

// >>> pif_flags_properties.sv
/*
  Checker for the peripheral flag block, bound to its ports.
  Assumes events and register port are synchronous to mclk.
*/
module pif_flags_properties
   import pif_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [PIF_ADDR_W-1:0] reg_addr,
   input wire logic [PIF_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [PIF_DATA_W-1:0] reg_rdata,
   input wire pif_events_s events,
   input wire logic periph_irq,
   input wire logic periph_pending
);
   logic cap;
   logic [7:0] hw;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // hardware sets; comparators apart, they need history
   assign cap = (events.ccp_mode == PIF_CCP_CAPTURE && events.capture_event) ||
      (events.ccp_mode == PIF_CCP_COMPARE && events.compare_match);
   assign hw = {events.eeprom_write_done, events.adc_conv_done, cap, 2'b00,
      events.osc_failed, events.timer_two_match, events.timer_one_overflow};
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_irq_gated: assert property (periph_irq |-> periph_pending)
      else $error("irq without pending");
   a_hw_sets: assert property ($past(reset_n) && reg_rd && reg_addr == PIF_OFS_FLAGS |=>
      (reg_rdata & $past(hw, 2)) == $past(hw, 2)) else $error("event flag lost");
   a_cmp_two: assert property ($past(reset_n, 2) && $past(reset_n) &&
      $changed(events.comparator_two_out) ##1 reg_rd && reg_addr == PIF_OFS_FLAGS
      |=> reg_rdata[PIF_BIT_CMP_TWO]) else $error("comparator two change lost");
   a_cmp_one: assert property ($past(reset_n, 2) && $past(reset_n) &&
      $changed(events.comparator_one_out) ##1 reg_rd && reg_addr == PIF_OFS_FLAGS
      |=> reg_rdata[PIF_BIT_CMP_ONE]) else $error("comparator one change lost");
   a_enable_reset: assert property (!$past(reset_n) && reg_rd &&
      reg_addr == PIF_OFS_ENABLE |=> reg_rdata == PIF_RST_ENABLE) else $error("enable not reset");
   a_enable_off: assert property (reg_wr && reg_addr == PIF_OFS_ENABLE &&
      reg_wdata == 8'h00 |=> ##1 !periph_pending) else $error("pending with no enable");
   a_global_off: assert property (reg_wr && reg_addr == PIF_OFS_CTRL &&
      !reg_wdata[PIF_BIT_GLOBAL_EN] |=> ##1 !periph_irq) else $error("irq with global off");
   cover property (periph_irq);
   cover property (reg_wr && reg_addr == PIF_OFS_FLAGS && |hw);
   cover property (events.ccp_mode == PIF_CCP_PWM && events.capture_event);
endmodule

bind pif_flags pif_flags_properties pif_flags_properties_inst (.mclk, .reset_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .events, .periph_irq, .periph_pending);

// >>> pif_periph_model.sv
/*
  Peripheral event sources: one-cycle pulses and comparator levels.
  Assumes the bench moves its controls just after a rising edge.
*/
module pif_periph_model
   import pif_pkg::*;
(
   input wire logic [7:0] fire,
   input wire logic [1:0] mode,
   input wire logic [1:0] cmp_lvl,
   output pif_events_s events
);
   // capture and compare pulse together; only the mode decides
   assign events = {fire[7], fire[6], fire[5], fire[5], mode, cmp_lvl, fire[2:0]};
endmodule

// >>> pif_flags_tb.sv
/*
  Bench for the peripheral flag block: register tasks and event pulses.
  Assumes block, checker and event model share one clock.
*/
module pif_flags_tb
   import pif_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] fire = 8'h00;
   logic [1:0] mode = 2'h1;
   logic [1:0] cmp_lvl = 2'h0;
   logic periph_irq;
   logic periph_pending;
   pif_events_s events;
   int miscompares = 0;
   int tests_run = 0;
   pif_periph_model pif_periph_model_inst (.fire, .mode, .cmp_lvl, .events);
   pif_flags pif_flags_inst (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .events, .periph_irq, .periph_pending);
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // idle edge at the end so two writes never touch the strobe at once
   task automatic wr(logic [3:0] a, logic [7:0] d);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e, string n);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(n, e, reg_rdata);
   endtask
   task automatic pulse(logic [7:0] f);
      fire <= f;
      @(posedge mclk);
      fire <= 8'h00;
   endtask
   // outputs are registered twice behind an event, so let two edges pass
   task automatic pin(string n, logic e, ref logic s);
      @(posedge mclk);
      @(posedge mclk);
      chk(n, {7'h00, e}, {7'h00, s});
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog, well above the roughly 110 cycles the tests need
   initial begin
      repeat (3000) @(posedge mclk);
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      rd(PIF_OFS_ENABLE, 8'h00, "enable reset");
      rd(PIF_OFS_FLAGS, 8'h00, "flags reset");
      wr(PIF_OFS_ENABLE, 8'ha5);
      rd(PIF_OFS_ENABLE, 8'ha5, "enable rw");
      wr(PIF_OFS_FLAGS, 8'h3c);
      rd(PIF_OFS_FLAGS, 8'h3c, "flags rw");
      wr(PIF_OFS_ENABLE, 8'h00);
      // each source alone, every enable off
      for (int i = 0; i < 8; i++) begin
         wr(PIF_OFS_FLAGS, 8'h00);
         if (i == 3 || i == 4) begin
            cmp_lvl <= cmp_lvl ^ 2'(i - 2);
            @(posedge mclk);
         end else pulse(8'h01 << i);
         rd(PIF_OFS_FLAGS, 8'h01 << i, "source flag");
      end
      // pwm and off modes must ignore the unit
      for (int m = 0; m < 4; m++) begin
         mode <= 2'(m);
         wr(PIF_OFS_FLAGS, 8'h00);
         pulse(8'h20);
         rd(PIF_OFS_FLAGS, (m == 1 || m == 2) ? 8'h20 : 8'h00, "capcomp mode");
      end
      fork
         pulse(8'h02);
         wr(PIF_OFS_FLAGS, 8'h00);
      join
      rd(PIF_OFS_FLAGS, 8'h02, "set beats clear");
      wr(PIF_OFS_FLAGS, 8'h00);
      wr(PIF_OFS_ENABLE, 8'h01);
      wr(PIF_OFS_CTRL, 8'h40);
      pulse(8'h02);
      pin("masked source", 1'b0, periph_pending);
      pulse(8'h01);
      pin("pending", 1'b1, periph_pending);
      chk("irq global off", 8'h00, {7'h00, periph_irq});
      rd(PIF_OFS_STATUS, 8'h01, "pending reg");
      wr(PIF_OFS_CTRL, 8'hff);
      rd(PIF_OFS_CTRL, 8'hc0, "ctrl rw");
      pin("irq raised", 1'b1, periph_irq);
      wr(PIF_OFS_FLAGS, 8'h00);
      pin("irq cleared", 1'b0, periph_irq);
      rd(4'hf, 8'h00, "unmapped");
      print_verdict();
   end
endmodule
